/* src/cmcc_ctrl.sv */
`timescale 1ns/1ps
`include "cmcc_map.svh"
// Operation
// - capacity 4K to 16K words, set in 4K steps by a parameter.
// - each access drives one bit in all mats: whole words only.
// - one X and one Y select line chosen together per access.
// - read drives word to zero, strobes sense; pulse is one.
// - after read the stack word is zero until written.
// - write only sets bits, so each write follows a read.
// - inhibit on for bits staying zero, off for bits becoming one.
// - a fetched word is written back to the same location.
// - every cycle is a read phase then a write phase.
// - cycle time is read phase, wait for the write edge, then write phase.
// - a full cycle completes within 2 microseconds.
// - above 4K the field number picks the 4K block.
// - falling edges of the initiate lines launch each phase.
// - inhibit starts before write drive and ends after it.
module cmcc_ctrl
	import cmcc_pkg::*;
#(
	parameter int FIELDS = 2,
	parameter int WB = `CMCC_WORD_BITS
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic READ_CYCLE_INITIATE_N,
	input wire logic WRITE_CYCLE_INITIATE_N,
	input wire logic WRITE_REQUEST,
	input wire logic [`CMCC_FIELD_ADDR_BITS-1:0] WORD_ADDR,
	input wire logic [`CMCC_FIELD_SEL_BITS-1:0] FIELD_ADDR,
	input wire logic [WB-1:0] WRITE_DATA,
	input wire logic [WB-1:0] SENSE_IN,
	output logic [WB-1:0] READ_DATA,
	output logic READ_DATA_VALID,
	output logic [WB-1:0] BIT_HOLD_DRIVE_ENABLE,
	output logic READ_DRIVE,
	output logic WRITE_DRIVE,
	output logic SENSE_STROBE,
	output logic [`CMCC_XY_LINES-1:0] X_SELECT,
	output logic [`CMCC_XY_LINES-1:0] Y_SELECT,
	output logic [`CMCC_MAX_FIELDS-1:0] FIELD_SELECT,
	output logic FIELD_ERROR,
	output logic CYCLE_BUSY
);
	// pulse lengths in clocks; the cycle counter saturates at the budget
	localparam int RD_LEN = `CMCC_READ_PULSE_CYC;
	localparam int ST_DLY = `CMCC_STROBE_DLY_CYC;
	localparam int LEAD = `CMCC_INHIBIT_LEAD_CYC;
	localparam int WR_LEN = `CMCC_WRITE_PULSE_CYC;
	localparam int TAIL = `CMCC_INHIBIT_TAIL_CYC;
	localparam int CYC_MAX = `CMCC_CYCLE_CYC;
	localparam int CW = $clog2(CYC_MAX + 1);

	// sequencer, captured request and sensed word
	cmcc_state_t state_r, state_nxt;
	// previous levels of the initiate lines, for edge detection
	logic rd_n_d_r, wr_n_d_r;
	logic [WB-1:0] word_r, word_nxt;
	logic is_write_r;
	// cycle position, counted from the read edge
	logic [CW-1:0] cyc_cnt_r;
	// end-of-pulse strobes of the four one-shots
	logic rd_done, lead_done, wr_done, tail_done;
	// processor-facing results
	logic [WB-1:0] read_data_r;
	logic read_valid_r;
	logic field_err_r;
	logic field_ok_r;
	logic busy_r;
	// drive lines toward the stack, registered
	cmcc_drive_t drv_r, drv_nxt;

	// falling edges of the phase initiate lines
	wire rd_fall = rd_n_d_r & ~READ_CYCLE_INITIATE_N;
	wire wr_fall = wr_n_d_r & ~WRITE_CYCLE_INITIATE_N;
	wire start_rd = rd_fall && (state_r == CMCC_IDLE);
	// write edge honoured only once the read current has ended
	wire start_wr = wr_fall && (state_r == CMCC_RD_WAIT);
	// a field beyond the installed count is refused and flagged
	wire field_ok = (32'(FIELD_ADDR) < 32'(FIELDS));
	// the check result must be live on the launch edge itself
	wire field_ok_now = start_rd ? field_ok : field_ok_r;
	// sense strobe a fixed delay into the read current
	wire strobe_now = (state_r == CMCC_RD_PULSE) &&
		(cyc_cnt_r == CW'(ST_DLY));
	// write-back word: new data for writes, sensed word otherwise
	// WRITE_DATA is used live, so it must stand until the cycle ends
	wire [WB-1:0] wb_word = is_write_r ? WRITE_DATA : word_r;

	// read drive pulse, launched by the read edge
	cmcc_pulse #(.LEN(RD_LEN)) u_rd (
		.clk(CORE_CLK), .rst_n(RST_N), .trig(start_rd),
		.busy(), .done(rd_done)
	);
	// lead, write and tail one-shots chain end to end, so the
	// hold drive brackets the write current on both sides
	// inhibit lead before write current
	cmcc_pulse #(.LEN(LEAD)) u_lead (
		.clk(CORE_CLK), .rst_n(RST_N), .trig(start_wr),
		.busy(), .done(lead_done)
	);
	// write drive pulse follows lead
	cmcc_pulse #(.LEN(WR_LEN)) u_wr (
		.clk(CORE_CLK), .rst_n(RST_N), .trig(lead_done),
		.busy(), .done(wr_done)
	);
	// inhibit tail after write current ends
	cmcc_pulse #(.LEN(TAIL)) u_tail (
		.clk(CORE_CLK), .rst_n(RST_N), .trig(wr_done),
		.busy(), .done(tail_done)
	);

	// phase sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			// wait for a read edge
			CMCC_IDLE: begin
				if (start_rd) begin
					state_nxt = CMCC_RD_PULSE;
				end
			end
			// read current on until its one-shot ends
			CMCC_RD_PULSE: begin
				if (rd_done) begin
					state_nxt = CMCC_RD_WAIT;
				end
			end
			// word is zero in the stack; wait for the write edge
			CMCC_RD_WAIT: begin
				if (start_wr) begin
					state_nxt = CMCC_WR_LEAD;
				end
			end
			// hold drive up ahead of the write current
			CMCC_WR_LEAD: begin
				if (lead_done) begin
					state_nxt = CMCC_WR_PULSE;
				end
			end
			// write current on
			CMCC_WR_PULSE: begin
				if (wr_done) begin
					state_nxt = CMCC_WR_TAIL;
				end
			end
			// hold drive kept past the write current
			CMCC_WR_TAIL: begin
				if (tail_done) begin
					state_nxt = CMCC_IDLE;
				end
			end
			default: state_nxt = CMCC_IDLE;
		endcase
	end

	// cleared on the read edge so a missed strobe reads as zero
	// sensed word: a pulse on a sense line means one
	always_comb begin
		word_nxt = word_r;
		if (start_rd) begin
			word_nxt = '0;
		end else if (strobe_now) begin
			word_nxt = SENSE_IN;
		end
	end

	// select numbers are captured once, on the read edge
	// drive lines toward the stack
	always_comb begin
		drv_nxt = drv_r;
		drv_nxt.read_drive = (state_nxt == CMCC_RD_PULSE);
		drv_nxt.write_drive = (state_nxt == CMCC_WR_PULSE);
		drv_nxt.sense_strobe = strobe_now;
		if (start_rd) begin
			// one x line, one y line from the word address
			drv_nxt.x_sel = WORD_ADDR[5:0];
			drv_nxt.y_sel = WORD_ADDR[11:6];
			drv_nxt.field_sel = FIELD_ADDR;
		end
	end

	// initiate lines are synchronous inputs, no extra stage
	// edge detect registers and sequencer state
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_n_d_r <= 1'b1;
			wr_n_d_r <= 1'b1;
			state_r <= CMCC_IDLE;
			word_r <= '0;
			drv_r <= '0;
		end else begin
			rd_n_d_r <= READ_CYCLE_INITIATE_N;
			wr_n_d_r <= WRITE_CYCLE_INITIATE_N;
			state_r <= state_nxt;
			word_r <= word_nxt;
			drv_r <= drv_nxt;
		end
	end

	// latch request function and field check on the read edge
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			is_write_r <= 1'b0;
			field_err_r <= 1'b0;
			field_ok_r <= 1'b0;
		end else if (start_rd) begin
			is_write_r <= WRITE_REQUEST;
			field_err_r <= ~field_ok;
			field_ok_r <= field_ok;
		end
	end

	// cycle counter: strobe timing, saturates at the cycle budget
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cyc_cnt_r <= '0;
		end else begin
			if (start_rd) begin
				cyc_cnt_r <= CW'(1);
			end else if (state_r != CMCC_IDLE &&
				cyc_cnt_r != CW'(CYC_MAX)) begin
				cyc_cnt_r <= cyc_cnt_r + CW'(1);
			end
		end
	end

	// writes leave the last read word in place
	// deliver sensed word to processor buffer on read requests
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			read_data_r <= '0;
			read_valid_r <= 1'b0;
		end else begin
			read_valid_r <= rd_done & ~is_write_r;
			if (rd_done && !is_write_r) begin
				read_data_r <= word_r;
			end
		end
	end

	// inhibit on for zero bits through lead, pulse and tail
	logic [WB-1:0] hold_r;
	wire inhibit_win = (state_nxt == CMCC_WR_LEAD) ||
		(state_nxt == CMCC_WR_PULSE) ||
		(state_nxt == CMCC_WR_TAIL);
	// one hold driver per bit, each mat has its own inhibit wire
	for (genvar b = 0; b < WB; b++) begin : g_hold
		always_ff @(posedge CORE_CLK or negedge RST_N) begin
			if (!RST_N) begin
				hold_r[b] <= 1'b0;
			end else begin
				hold_r[b] <= inhibit_win & ~wb_word[b];
			end
		end
	end

	// one-hot select decode, same lines in every mat
	logic [`CMCC_XY_LINES-1:0] xsel_r, ysel_r;
	logic [`CMCC_MAX_FIELDS-1:0] fsel_r;
	// selects stay up through lead and tail with the hold drive
	wire drv_any = drv_nxt.read_drive | drv_nxt.write_drive |
		inhibit_win;
	// one-hot decode of the captured line and field numbers
	wire [`CMCC_XY_LINES-1:0] x_onehot = 64'h1 << drv_nxt.x_sel;
	wire [`CMCC_XY_LINES-1:0] y_onehot = 64'h1 << drv_nxt.y_sel;
	wire [`CMCC_MAX_FIELDS-1:0] f_onehot = 4'h1 << drv_nxt.field_sel;
	// an unused field keeps the field select off
	wire f_en = drv_any & field_ok_now;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			xsel_r <= '0;
			ysel_r <= '0;
			fsel_r <= '0;
		end else begin
			xsel_r <= drv_any ? x_onehot : '0;
			ysel_r <= drv_any ? y_onehot : '0;
			fsel_r <= f_en ? f_onehot : '0;
		end
	end
	// busy from a flop, same timing as the state register
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= (state_nxt != CMCC_IDLE);
		end
	end

	// busy clears with the last hold drive edge
	// outputs straight from flip-flops
	assign READ_DATA = read_data_r;
	assign READ_DATA_VALID = read_valid_r;
	assign BIT_HOLD_DRIVE_ENABLE = hold_r;
	assign READ_DRIVE = drv_r.read_drive;
	assign WRITE_DRIVE = drv_r.write_drive;
	assign SENSE_STROBE = drv_r.sense_strobe;
	assign X_SELECT = xsel_r;
	assign Y_SELECT = ysel_r;
	assign FIELD_SELECT = fsel_r;
	assign FIELD_ERROR = field_err_r;
	assign CYCLE_BUSY = busy_r;
endmodule

/* src/cmcc_map.svh */
`ifndef CMCC_MAP_SVH
`define CMCC_MAP_SVH
// capacity and addressing
`define CMCC_WORD_BITS 12
`define CMCC_FIELD_WORDS 4096
`define CMCC_FIELD_ADDR_BITS 12
`define CMCC_FIELD_SEL_BITS 2
`define CMCC_MAX_FIELDS 4
`define CMCC_XY_BITS 6
`define CMCC_XY_LINES 64
// timing in nanoseconds
`define CMCC_CLK_NS 25
`define CMCC_CYCLE_NS 2000
`define CMCC_STROBE_DLY_NS 300
`define CMCC_READ_PULSE_NS 600
`define CMCC_INHIBIT_LEAD_NS 100
`define CMCC_WRITE_PULSE_NS 600
`define CMCC_INHIBIT_TAIL_NS 50
// cycle counts: least times round up
`define CMCC_STROBE_DLY_CYC \
	((`CMCC_STROBE_DLY_NS + `CMCC_CLK_NS - 1) / `CMCC_CLK_NS)
`define CMCC_READ_PULSE_CYC \
	((`CMCC_READ_PULSE_NS + `CMCC_CLK_NS - 1) / `CMCC_CLK_NS)
`define CMCC_INHIBIT_LEAD_CYC \
	((`CMCC_INHIBIT_LEAD_NS + `CMCC_CLK_NS - 1) / `CMCC_CLK_NS)
`define CMCC_WRITE_PULSE_CYC \
	((`CMCC_WRITE_PULSE_NS + `CMCC_CLK_NS - 1) / `CMCC_CLK_NS)
`define CMCC_INHIBIT_TAIL_CYC \
	((`CMCC_INHIBIT_TAIL_NS + `CMCC_CLK_NS - 1) / `CMCC_CLK_NS)
// longest time rounds down
`define CMCC_CYCLE_CYC (`CMCC_CYCLE_NS / `CMCC_CLK_NS)
`endif

/* src/cmcc_pkg.sv */
package cmcc_pkg;
	// phase sequencer states, gray from idle to write tail; tail back to idle flips all three bits
	typedef enum logic [2:0] {
		CMCC_IDLE = 3'h0,
		CMCC_RD_PULSE = 3'h1,
		CMCC_RD_WAIT = 3'h3,
		CMCC_WR_LEAD = 3'h2,
		CMCC_WR_PULSE = 3'h6,
		CMCC_WR_TAIL = 3'h7
	} cmcc_state_t;

	// drive lines toward the stack
	typedef struct packed {
		logic read_drive;
		logic write_drive;
		logic sense_strobe;
		logic [5:0] x_sel;
		logic [5:0] y_sel;
		logic [1:0] field_sel;
	} cmcc_drive_t;
endpackage

/* src/cmcc_pulse.sv */
`timescale 1ns/1ps
`include "cmcc_map.svh"
// one-shot: starts on a trigger, holds busy for LEN cycles
module cmcc_pulse #(
	parameter int LEN = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic trig,
	output logic busy,
	output logic done
);
	localparam int CW = $clog2(LEN + 1);
	logic [CW-1:0] cnt_r;
	wire last = (cnt_r == CW'(1));

	// count down while running
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (trig) begin
			cnt_r <= CW'(LEN);
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - CW'(1);
		end
	end
	assign busy = (cnt_r != '0);
	assign done = last;
endmodule

/* test/cmcc_sva.sv */
`timescale 1ns/1ps
// timing and select checks on the controller's ports
module cmcc_sva #(
	parameter int FIELDS = 2
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic READ_CYCLE_INITIATE_N,
	input wire logic WRITE_REQUEST,
	input wire logic [11:0] WORD_ADDR,
	input wire logic [1:0] FIELD_ADDR,
	input wire logic [11:0] WRITE_DATA,
	input wire logic [11:0] READ_DATA,
	input wire logic [11:0] BIT_HOLD_DRIVE_ENABLE,
	input wire logic READ_DRIVE,
	input wire logic WRITE_DRIVE,
	input wire logic SENSE_STROBE,
	input wire logic [63:0] X_SELECT,
	input wire logic [63:0] Y_SELECT,
	input wire logic [3:0] FIELD_SELECT,
	input wire logic CYCLE_BUSY
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);
	// both current windows last exactly 24 cycles
	property p_rd;
		$rose(READ_DRIVE) |-> ##23 READ_DRIVE ##1 !READ_DRIVE;
	endproperty
	a_rd: assert property (p_rd)
		else $error("read drive length wrong");
	property p_wr;
		$rose(WRITE_DRIVE) |-> ##23 WRITE_DRIVE ##1 !WRITE_DRIVE;
	endproperty
	a_wr: assert property (p_wr)
		else $error("write drive length wrong");
	// falling initiate line in idle launches the read window
	property p_go;
		$fell(READ_CYCLE_INITIATE_N) && !CYCLE_BUSY |=> READ_DRIVE;
	endproperty
	a_go: assert property (p_go)
		else $error("read phase not launched");
	property p_stb;
		$rose(READ_DRIVE) |-> ##[8:16] SENSE_STROBE;
	endproperty
	a_stb: assert property (p_stb)
		else $error("sense strobe missing");
	// hold drive set before and kept past the write window
	property p_inh;
		WRITE_DRIVE || $past(WRITE_DRIVE) |-> $stable(BIT_HOLD_DRIVE_ENABLE);
	endproperty
	a_inh: assert property (p_inh)
		else $error("hold drive moved in write window");
	property p_bits;
		WRITE_DRIVE |-> BIT_HOLD_DRIVE_ENABLE ==
			~(WRITE_REQUEST ? WRITE_DATA : READ_DATA);
	endproperty
	a_bits: assert property (p_bits)
		else $error("hold bits wrong");
	property p_sel;
		READ_DRIVE |-> X_SELECT == 64'h1 << WORD_ADDR[5:0] &&
			Y_SELECT == 64'h1 << WORD_ADDR[11:6];
	endproperty
	a_sel: assert property (p_sel)
		else $error("x or y select wrong");
	property p_fld;
		READ_DRIVE |-> FIELD_SELECT ==
			(FIELD_ADDR < FIELDS ? 4'h1 << FIELD_ADDR : 4'h0);
	endproperty
	a_fld: assert property (p_fld)
		else $error("field select wrong");
endmodule

bind cmcc_ctrl cmcc_sva #(.FIELDS(FIELDS)) u_sva (
	.CORE_CLK(CORE_CLK), .RST_N(RST_N),
	.READ_CYCLE_INITIATE_N(READ_CYCLE_INITIATE_N),
	.WRITE_REQUEST(WRITE_REQUEST), .WORD_ADDR(WORD_ADDR),
	.FIELD_ADDR(FIELD_ADDR), .WRITE_DATA(WRITE_DATA),
	.READ_DATA(READ_DATA), .BIT_HOLD_DRIVE_ENABLE(BIT_HOLD_DRIVE_ENABLE),
	.READ_DRIVE(READ_DRIVE), .WRITE_DRIVE(WRITE_DRIVE),
	.SENSE_STROBE(SENSE_STROBE), .X_SELECT(X_SELECT),
	.Y_SELECT(Y_SELECT), .FIELD_SELECT(FIELD_SELECT),
	.CYCLE_BUSY(CYCLE_BUSY)
);

/* test/cmcc_cpu.sv */
`timescale 1ns/1ps
// processor side: issues read then write initiate edges
module cmcc_cpu (
	input wire logic clk,
	input wire logic rdrv,
	input wire logic busy,
	output logic rd_n,
	output logic wr_n,
	output logic wreq,
	output logic [11:0] addr,
	output logic [1:0] fld,
	output logic [11:0] wdata
);
	initial begin
		rd_n = 1'b1;
		wr_n = 1'b1;
		{wreq, addr, fld, wdata} = '0;
	end
	// one full memory cycle, data held until idle
	task automatic cycle(input logic w, input logic [11:0] a,
		input logic [1:0] f, input logic [11:0] d);
		int n = 0;
		@(posedge clk);
		{wreq, addr, fld, wdata} <= {w, a, f, d};
		rd_n <= 1'b0;
		do @(negedge clk); while (rdrv !== 1'b1 && ++n < 40);
		n = 0;
		do @(negedge clk); while (rdrv !== 1'b0 && ++n < 40);
		@(posedge clk);
		rd_n <= 1'b1;
		wr_n <= 1'b0;
		n = 0;
		do @(negedge clk); while (busy !== 1'b0 && ++n < 60);
		@(posedge clk);
		wr_n <= 1'b1;
		wdata <= ~d;
		@(negedge clk);
	endtask
	// write edge with no read phase before it
	task automatic lone_wr;
		@(posedge clk);
		wr_n <= 1'b0;
		repeat (8) @(posedge clk);
		wr_n <= 1'b1;
	endtask
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
	localparam int NF = 3;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rd_n, wr_n, wreq, rdrv, wdrv, stb, busy, vld, ferr;
	logic [11:0] addr, wdata, rdata, hold, sense;
	logic [1:0] fld;
	logic [63:0] xs, ys;
	logic [3:0] fs;
	logic [11:0] mem [0:16383];
	logic seen = 1'b0;
	logic was = 1'b0;
	int bc = 0;
	int n_vld = 0;
	int n_fail = 0;
	int check_count = 0;
	wire [13:0] idx = {fld, addr};
	always #12.5 clk = ~clk;
	// stack: destructive read, write sets bits not held
	assign sense = rdrv ? mem[idx] : ~mem[idx];
	always @(negedge clk) begin
		if (rdrv) seen <= 1'b1;
		if (seen && !rdrv) begin
			mem[idx] <= '0;
			seen <= 1'b0;
		end
		if (wdrv) mem[idx] <= mem[idx] | ~hold;
	end
	// length of the last busy span, count of read data pulses
	always @(posedge clk) begin
		was <= busy;
		if (busy) bc <= was ? bc + 1 : 1;
		if (vld) n_vld <= n_vld + 1;
	end
	cmcc_ctrl #(.FIELDS(NF)) u_dut (
		.CORE_CLK(clk), .RST_N(rst_n), .READ_CYCLE_INITIATE_N(rd_n),
		.WRITE_CYCLE_INITIATE_N(wr_n), .WRITE_REQUEST(wreq),
		.WORD_ADDR(addr), .FIELD_ADDR(fld), .WRITE_DATA(wdata),
		.SENSE_IN(sense), .READ_DATA(rdata), .READ_DATA_VALID(vld),
		.BIT_HOLD_DRIVE_ENABLE(hold), .READ_DRIVE(rdrv),
		.WRITE_DRIVE(wdrv), .SENSE_STROBE(stb), .X_SELECT(xs),
		.Y_SELECT(ys), .FIELD_SELECT(fs), .FIELD_ERROR(ferr),
		.CYCLE_BUSY(busy)
	);
	cmcc_cpu u_cpu (
		.clk(clk), .rdrv(rdrv), .busy(busy), .rd_n(rd_n), .wr_n(wr_n),
		.wreq(wreq), .addr(addr), .fld(fld), .wdata(wdata)
	);
	task automatic chk_w(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t word %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t flag %b want %b", $time, got, exp);
		end
	endtask
	// field above the installed count flags an error
	task automatic t_field;
		u_cpu.cycle(1'b1, 12'h040, 2'h3, 12'h123);
		chk_b(ferr, 1'b1);
	endtask
	// store, then read twice: the second read sees the restored word
	task automatic t_store;
		logic [11:0] a [3] = '{12'h000, 12'hFFF, 12'h5A3};
		logic [11:0] d [3] = '{12'hFFF, 12'h000, 12'hA5C};
		for (int i = 0; i < 3; i++) begin
			u_cpu.cycle(1'b1, a[i], i[1:0], d[i]);
			chk_b(bc <= 80, 1'b1);
			chk_b(ferr, 1'b0);
			u_cpu.cycle(1'b0, a[i], i[1:0], ~d[i]);
			chk_w(rdata, d[i]);
			u_cpu.cycle(1'b0, a[i], i[1:0], 12'h3C3);
			chk_w(rdata, d[i]);
		end
		chk_b(n_vld == 6, 1'b1);
	endtask
	// a write edge in idle starts nothing
	task automatic t_refuse;
		u_cpu.lone_wr();
		@(negedge clk);
		chk_b(busy, 1'b0);
		chk_b(wdrv, 1'b0);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_field();
		t_store();
		t_refuse();
		test_done();
	end
	// hang guard: far beyond ten cycles of 80 clocks
	initial begin
		#200000;
		n_fail++;
		test_done();
	end
endmodule
